/* verification/ppd_osc_model.sv */
module ppd_osc_model (
    // control
    input  wire logic       pclk,
    input  wire logic       run,
    input  wire logic [3:0] half,
    // pins
    output logic            ref_pin,
    output logic            fb_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt = 4'h0;
    logic       lvl = 1'b0;
    // one source feeds both pins so equal ratios wrap on the same edge
    always_ff @(posedge pclk) begin
        if (run && cnt == half - 4'h1) begin
            cnt <= 4'h0;
            lvl <= !lvl;
        end else if (run) begin
            cnt <= cnt + 4'h1;
        end
    end
    assign ref_pin = lvl;
    assign fb_pin  = lvl;
endmodule : ppd_osc_model

/* verification/ppd_synth_core_bench.sv */
module ppd_synth_core_bench
    import ppd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic        run = 1'b0;
    logic [31:0] prdata, q;
    logic        pready, pslverr, err, se_out, se_oe_n, ref_n, fb_n, div_out, lock, irq;
    logic        ref_pin, fb_pin;
    int          fails = 0;
    int          checks = 0;

    always #10 pclk = !pclk;

    ppd_osc_model osc_u (.pclk(pclk), .run(run), .half(4'h2), .ref_pin(ref_pin), .fb_pin(fb_pin));

    ppd_synth_core dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reference_osc_in(ref_pin), .freq_in(fb_pin), .single_ended_error_out(se_out),
        .single_ended_error_oe_n(se_oe_n), .ref_side_error_n(ref_n), .fb_side_error_n(fb_n),
        .divided_feedback_out(div_out), .lock_indicator(lock), .irq(irq)
    );

    task automatic complete_run();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fails++;
            complete_run();
        end
    endtask : apb

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset

    // pins halted while programming so both dividers reload in step
    task automatic t_ratio(input logic [3:0] ctrl, input logic [13:0] fb, input int e,
                           input logic [3:0] exp);
        logic [3:0] seen;
        seen = 4'h0;
        apb(1'b1, PPD_CTRL_OFF, {28'h0, ctrl});
        apb(1'b1, PPD_FBVAL_OFF, {18'h0, fb});
        run <= 1'b1;
        repeat (e * 4) begin
            @(negedge pclk);
            seen |= {div_out, !lock, !fb_n && ref_n, !ref_n && fb_n};
        end
        @(posedge pclk);
        run <= 1'b0;
        repeat (8) @(posedge pclk);
        check({28'h0, seen}, {28'h0, exp});
    endtask : t_ratio

    // previous run stops after a reference wrap with the feedback wrap still pending
    task automatic t_irq();
        apb(1'b0, PPD_STATUS_OFF, 32'h00000000);
        check(q, 32'h00000002);
        check({31'h0, lock}, 32'h00000000);
        apb(1'b0, PPD_INT_STAT_OFF, 32'h00000000);
        @(negedge pclk);
        check({31'h0, q[PPD_INT_LAG_BIT]}, 32'h00000001);
        check({31'h0, irq}, 32'h00000000);
        apb(1'b1, PPD_INT_MASK_OFF, 32'h00000002);
        @(negedge pclk);
        check({31'h0, irq}, 32'h00000001);
        apb(1'b1, PPD_INT_STAT_OFF, 32'h00000007);
        @(negedge pclk);
        check({31'h0, irq}, 32'h00000000);
        // back on a rising edge so the following reset is driven there
        @(posedge pclk);
    endtask : t_irq

    // ratio 8192 left out: two wraps would exceed the run budget
    initial begin
        do_reset();
        apb(1'b0, PPD_CTRL_OFF, 32'h00000000);
        check(q, 32'h0000000F);
        check({31'h0, err}, 32'h00000000);
        apb(1'b0, PPD_FBVAL_OFF, 32'h00000000);
        check(q, 32'h00003FFF);
        apb(1'b0, 12'h014, 32'h00000000);
        check({q[30:0], err}, 32'h00000001);
        t_ratio(4'h8, 14'h0008, 20, 4'h8);
        t_ratio(4'h8, 14'h0009, 40, 4'hD);
        t_irq();
        do_reset();
        t_ratio(4'h8, 14'h0007, 40, 4'hE);
        // after the joint first wrap feedback always wraps first: lead and lock-lost events only
        apb(1'b0, PPD_INT_STAT_OFF, 32'h00000000);
        check(q, 32'h00000005);
        check({31'h0, lock}, 32'h00000000);
        do_reset();
        t_ratio(4'h9, 14'h0080, 260, 4'h8);
        t_ratio(4'hA, 14'h0100, 516, 4'h8);
        t_ratio(4'hB, 14'h0200, 1028, 4'h8);
        t_ratio(4'hC, 14'h0400, 2052, 4'h8);
        t_ratio(4'hD, 14'h0800, 4100, 4'h8);
        t_ratio(4'h4, 14'h00A8, 2052, 4'h8);
        t_ratio(4'h6, 14'h0612, 4824, 4'h8);
        complete_run();
    end
endmodule : ppd_synth_core_bench

/* verification/ppd_synth_core_properties.sv */
module ppd_synth_core_checker
    import ppd_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // detector pins
    input wire logic single_ended_error_out,
    input wire logic single_ended_error_oe_n,
    input wire logic ref_side_error_n,
    input wire logic fb_side_error_n,
    input wire logic lock_indicator
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire ref_lo  = !ref_side_error_n && fb_side_error_n;
    wire fb_lo   = !fb_side_error_n && ref_side_error_n;
    wire both_lo = !ref_side_error_n && !fb_side_error_n;
    AST_REF_LEAD: assert property (
        ref_lo |-> !single_ended_error_oe_n && single_ended_error_out)
        else $error("single-ended not driven high on reference lead");
    AST_FB_LEAD: assert property (
        fb_lo |-> !single_ended_error_oe_n && !single_ended_error_out)
        else $error("single-ended not driven low on feedback lead");
    AST_IDLE_HIZ: assert property (
        !(ref_lo || fb_lo) |-> single_ended_error_oe_n)
        else $error("single-ended driven while in phase");
    AST_LOCK_DROP: assert property (
        (ref_lo || fb_lo) |-> !lock_indicator)
        else $error("lock high during one-sided error");
    AST_LOCK_HOLD: assert property (
        !(ref_lo || fb_lo) |-> lock_indicator)
        else $error("lock low without error");
    AST_BOTH_WIDTH: assert property (
        $rose(both_lo) |-> both_lo [*3] ##1 !both_lo)
        else $error("joint low pulse width wrong");
    AST_REF_TO_BOTH: assert property (
        ref_lo |=> ref_lo || both_lo)
        else $error("reference-side error ended without feedback edge");
    AST_FB_TO_BOTH: assert property (
        fb_lo |=> fb_lo || both_lo)
        else $error("feedback-side error ended without reference edge");
endmodule : ppd_synth_core_checker

bind ppd_synth_core ppd_synth_core_checker chk_u (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .single_ended_error_out  (single_ended_error_out),
    .single_ended_error_oe_n (single_ended_error_oe_n),
    .ref_side_error_n        (ref_side_error_n),
    .fb_side_error_n         (fb_side_error_n),
    .lock_indicator          (lock_indicator)
);

/* verilog/ppd_pkg.sv */
package ppd_pkg;

    // register offsets (byte addresses, one word each)
    localparam logic [11:0] PPD_CTRL_OFF     = 12'h000;
    localparam logic [11:0] PPD_FBVAL_OFF    = 12'h004;
    localparam logic [11:0] PPD_STATUS_OFF   = 12'h008;
    localparam logic [11:0] PPD_INT_STAT_OFF = 12'h00C;
    localparam logic [11:0] PPD_INT_MASK_OFF = 12'h010;

    // field positions
    localparam int PPD_CTRL_REFSEL_LSB = 0;
    localparam int PPD_CTRL_OFFSEL_BIT = 3;
    localparam int PPD_INT_LEAD_BIT    = 0;
    localparam int PPD_INT_LAG_BIT     = 1;
    localparam int PPD_INT_UNLOCK_BIT  = 2;

    // values after reset: open strap inputs read as ones
    localparam logic [2:0]  PPD_REFSEL_RST  = 3'h7;
    localparam logic        PPD_OFFSEL_RST  = 1'h1;
    localparam logic [13:0] PPD_FBVAL_RST   = 14'h3FFF;
    localparam logic [2:0]  PPD_INT_RST     = 3'h0;

    // divider constants
    localparam logic [14:0] PPD_TR_OFFSET   = 15'h0358;
    localparam logic [13:0] PPD_RATIO_0     = 14'h0008;
    localparam logic [13:0] PPD_RATIO_1     = 14'h0080;
    localparam logic [13:0] PPD_RATIO_2     = 14'h0100;
    localparam logic [13:0] PPD_RATIO_3     = 14'h0200;
    localparam logic [13:0] PPD_RATIO_4     = 14'h0400;
    localparam logic [13:0] PPD_RATIO_5     = 14'h0800;
    localparam logic [13:0] PPD_RATIO_6     = 14'h096A;
    localparam logic [13:0] PPD_RATIO_7     = 14'h2000;

    // timing
    localparam int PPD_CLK_PERIOD_NS = 20;
    localparam int PPD_MIN_PULSE_NS  = 60;
    localparam int PPD_MIN_PULSE_INT =
        (PPD_MIN_PULSE_NS + PPD_CLK_PERIOD_NS - 1) / PPD_CLK_PERIOD_NS;
    localparam logic [3:0] PPD_MIN_PULSE_CYC = PPD_MIN_PULSE_INT[3:0];

    // detector states, gray along idle -> one side -> both; both -> idle flips two bits
    typedef enum logic [1:0] {
        PPD_IDLE   = 2'h0,
        PPD_REF_UP = 2'h1,
        PPD_BOTH   = 2'h3,
        PPD_FB_DN  = 2'h2
    } ppd_pfd_e_t;

    typedef struct packed {
        logic        offset_select;
        logic [2:0]  ref_select;
    } ppd_ctrl_t;

    typedef struct packed {
        logic [1:0]  ref_sync;
        logic        ref_prev;
        logic [1:0]  fb_sync;
        logic        fb_prev;
        logic [13:0] ref_cnt;
        logic [14:0] fb_cnt;
        logic        fb_out;
        ppd_pfd_e_t  pfd;
        logic [3:0]  min_cnt;
        logic        ref_low;
        logic        fb_low;
        logic        lock;
        ppd_ctrl_t   ctrl;
        logic [13:0] fb_value;
        logic [2:0]  int_stat;
        logic [2:0]  int_mask;
        logic [31:0] rdata;
        logic        slverr;
    } ppd_state_t;

endpackage : ppd_pkg

/* verilog/ppd_synth_core.sv */
//Contract
// [R01] Reference divider ratio follows the three-bit select: 8,128,256,512,1024,2048,2410,8192.
// [R02] Feedback divider reloads the programmed value on reaching zero and keeps counting.
// [R03] Feedback value is a 14-bit word, bit 0 least significant.
// [R04] Software programs a feedback ratio between 3 and 16383.
// [R05] Offset select low adds 856 to the feedback value; high adds nothing.
// [R06] Divide-value and reference select bits read as one when not programmed.
// [R07] Single-ended output: low when feedback leads, high when lagging, else undriven.
// [R08] Feedback leading or faster: feedback-side output pulses low, reference side high.
// [R09] Feedback lagging or slower: reference-side output pulses low, feedback side high.
// [R10] In lock both double-ended outputs pulse low together for a minimum width.
// [R11] Divided feedback signal fed to the detector is also driven out.
// [R12] Lock indicator high while in lock, pulses low when out of lock.
// [R13] Dividers step on rising edges of their own input clocks.
// [R14] Detector compares divider output edges and pulses for the time between them.
//
// The register offsets and register access over APB were chosen for this implementation.
module ppd_synth_core
    import ppd_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // synthesizer pins
    input  wire logic        reference_osc_in,
    input  wire logic        freq_in,
    output logic             single_ended_error_out,
    output logic             single_ended_error_oe_n,
    output logic             ref_side_error_n,
    output logic             fb_side_error_n,
    output logic             divided_feedback_out,
    output logic             lock_indicator,
    // interrupt
    output logic             irq
);

    ppd_state_t st;
    ppd_state_t next_st;

    logic        ref_edge;
    logic        fb_edge;
    logic        ref_evt;
    logic        fb_evt;
    logic [14:0] fb_total;
    logic        setup_phase;
    logic        wr_access;
    logic [31:0] rd_word;
    logic        rd_hit;

    function automatic logic [13:0] ref_ratio(input logic [2:0] sel);
        case (sel)
            3'h0:    ref_ratio = PPD_RATIO_0;
            3'h1:    ref_ratio = PPD_RATIO_1;
            3'h2:    ref_ratio = PPD_RATIO_2;
            3'h3:    ref_ratio = PPD_RATIO_3;
            3'h4:    ref_ratio = PPD_RATIO_4;
            3'h5:    ref_ratio = PPD_RATIO_5;
            3'h6:    ref_ratio = PPD_RATIO_6;
            default: ref_ratio = PPD_RATIO_7;
        endcase
    endfunction : ref_ratio

    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == PPD_CTRL_OFF) || (a == PPD_FBVAL_OFF) ||
                   (a == PPD_STATUS_OFF) || (a == PPD_INT_STAT_OFF) ||
                   (a == PPD_INT_MASK_OFF);
    endfunction : addr_hit

    // both pin inputs cross into pclk through two flops first
    assign ref_edge = st.ref_sync[1] & ~st.ref_prev;  // [R13]
    assign fb_edge  = st.fb_sync[1] & ~st.fb_prev;    // [R13]

    // divider terminal events feed the detector
    assign ref_evt = ref_edge && (st.ref_cnt <= 14'h0001);
    assign fb_evt  = fb_edge && (st.fb_cnt <= 15'h0001);

    always_comb begin
        fb_total = {1'b0, st.fb_value};                 // [R03]
        if (!st.ctrl.offset_select) begin
            fb_total = fb_total + PPD_TR_OFFSET;        // [R05]
        end
    end

    assign setup_phase = psel && !penable;
    assign wr_access   = psel && penable && pwrite && addr_hit(paddr);
    assign rd_hit      = addr_hit(paddr);

    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr)
            PPD_CTRL_OFF: begin
                rd_word[PPD_CTRL_OFFSEL_BIT] = st.ctrl.offset_select;
                rd_word[PPD_CTRL_REFSEL_LSB +: 3] = st.ctrl.ref_select;
            end
            PPD_FBVAL_OFF: begin
                rd_word[13:0] = st.fb_value;
            end
            PPD_STATUS_OFF: begin
                rd_word[0]   = st.lock;
                rd_word[2:1] = st.pfd;
                rd_word[3]   = st.fb_out;
            end
            PPD_INT_STAT_OFF: begin
                rd_word[2:0] = st.int_stat;
            end
            PPD_INT_MASK_OFF: begin
                rd_word[2:0] = st.int_mask;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        next_st = st;

        next_st.ref_sync = {st.ref_sync[0], reference_osc_in};
        next_st.ref_prev = st.ref_sync[1];
        next_st.fb_sync  = {st.fb_sync[0], freq_in};
        next_st.fb_prev  = st.fb_sync[1];

        // reference divider; a select change takes hold at the next wrap
        if (ref_edge) begin
            if (st.ref_cnt <= 14'h0001) begin
                next_st.ref_cnt = ref_ratio(st.ctrl.ref_select);  // [R01]
            end else begin
                next_st.ref_cnt = st.ref_cnt - 14'h0001;          // [R13]
            end
        end

        // feedback divider picks up the current value at every reload
        if (fb_edge) begin
            if (st.fb_cnt <= 15'h0001) begin
                next_st.fb_cnt = fb_total;                       // [R02]
            end else begin
                next_st.fb_cnt = st.fb_cnt - 15'h0001;           // [R13]
            end
        end
        next_st.fb_out = (next_st.fb_cnt > (fb_total >> 1));      // [R11]

        // phase/frequency detector on the divider edges
        case (st.pfd)
            PPD_IDLE: begin
                if (ref_evt && fb_evt) begin
                    next_st.pfd     = PPD_BOTH;                  // [R10]
                    next_st.min_cnt = PPD_MIN_PULSE_CYC;
                end else if (ref_evt) begin
                    next_st.pfd = PPD_REF_UP;                    // [R14]
                end else if (fb_evt) begin
                    next_st.pfd = PPD_FB_DN;                     // [R14]
                end
            end
            PPD_REF_UP: begin
                if (fb_evt) begin
                    next_st.pfd     = PPD_BOTH;
                    next_st.min_cnt = PPD_MIN_PULSE_CYC;
                end
            end
            PPD_FB_DN: begin
                if (ref_evt) begin
                    next_st.pfd     = PPD_BOTH;
                    next_st.min_cnt = PPD_MIN_PULSE_CYC;
                end
            end
            PPD_BOTH: begin
                // edges inside the reset window are dropped; window is a few pclk only
                if (st.min_cnt <= 4'h1) begin
                    next_st.pfd     = PPD_IDLE;
                    next_st.min_cnt = 4'h0;
                end else begin
                    next_st.min_cnt = st.min_cnt - 4'h1;
                end
            end
            default: begin
                next_st.pfd = PPD_IDLE;
            end
        endcase

        next_st.fb_low  = (next_st.pfd == PPD_FB_DN) ||
                          (next_st.pfd == PPD_BOTH);             // [R08]
        next_st.ref_low = (next_st.pfd == PPD_REF_UP) ||
                          (next_st.pfd == PPD_BOTH);             // [R09]
        next_st.lock    = !((next_st.pfd == PPD_FB_DN) ||
                            (next_st.pfd == PPD_REF_UP));        // [R12]

        // register writes
        if (wr_access) begin
            case (paddr)
                PPD_CTRL_OFF: begin
                    next_st.ctrl.ref_select    = pwdata[PPD_CTRL_REFSEL_LSB +: 3];
                    next_st.ctrl.offset_select = pwdata[PPD_CTRL_OFFSEL_BIT];
                end
                PPD_FBVAL_OFF: begin
                    next_st.fb_value = pwdata[13:0];             // [R03]
                end
                PPD_INT_STAT_OFF: begin
                    next_st.int_stat = st.int_stat & ~pwdata[2:0];
                end
                PPD_INT_MASK_OFF: begin
                    next_st.int_mask = pwdata[2:0];
                end
                default: begin
                    next_st.int_mask = st.int_mask;
                end
            endcase
        end

        // sticky events, applied after the clear so a new event wins
        if ((st.pfd == PPD_IDLE) && !ref_evt && fb_evt) begin
            next_st.int_stat[PPD_INT_LEAD_BIT] = 1'b1;
        end
        if ((st.pfd == PPD_IDLE) && ref_evt && !fb_evt) begin
            next_st.int_stat[PPD_INT_LAG_BIT] = 1'b1;
        end
        if (st.lock && !next_st.lock) begin
            next_st.int_stat[PPD_INT_UNLOCK_BIT] = 1'b1;
        end

        // read data captured in setup so access completes with no wait
        if (setup_phase) begin
            next_st.rdata  = rd_word;
            next_st.slverr = !rd_hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st                    <= '0;
            st.pfd                <= PPD_IDLE;
            st.lock               <= 1'b1;
            st.ctrl.ref_select    <= PPD_REFSEL_RST;            // [R06]
            st.ctrl.offset_select <= PPD_OFFSEL_RST;            // [R06]
            st.fb_value           <= PPD_FBVAL_RST;             // [R06]
            st.int_stat           <= PPD_INT_RST;
            st.int_mask           <= PPD_INT_RST;
        end else begin
            st <= next_st;
        end
    end

    // apb answer
    assign pready  = 1'b1;
    assign prdata  = st.rdata;
    assign pslverr = psel && penable && st.slverr;

    // detector pins
    assign fb_side_error_n  = !st.fb_low;
    assign ref_side_error_n = !st.ref_low;

    always_comb begin
        single_ended_error_out  = 1'b0;
        single_ended_error_oe_n = 1'b1;
        if (st.fb_low && !st.ref_low) begin
            single_ended_error_out  = 1'b0;                      // [R07]
            single_ended_error_oe_n = 1'b0;
        end else if (st.ref_low && !st.fb_low) begin
            single_ended_error_out  = 1'b1;                      // [R07]
            single_ended_error_oe_n = 1'b0;
        end
    end

    assign divided_feedback_out = st.fb_out;                     // [R11]
    assign lock_indicator       = st.lock;                       // [R12]
    assign irq                  = |(st.int_stat & st.int_mask);

endmodule : ppd_synth_core
